// ---- include/ssp_pkg.sv ----
// constants, types and helpers shared by the serial shift port
package ssp_pkg;
    // bus shape
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_GDATA = 8'hd4;
    localparam logic [7:0] IDX_GCFG  = 8'hd5;
    localparam logic [7:0] IDX_GPIN  = 8'hd6;
    localparam logic [7:0] IDX_SIO   = 8'he9;
    localparam logic [7:0] IDX_CTRL  = 8'hee;
    localparam logic [7:0] IDX_PSW   = 8'hef;
    // control and status field positions
    localparam int CTRL_SL0  = 0;
    localparam int CTRL_SL1  = 1;
    localparam int CTRL_SERIAL_PORT_SELECT = 3;
    localparam int PSW_BUSY  = 2;
    // port pin roles
    localparam int PIN_SO   = 4;
    localparam int PIN_SK   = 5;
    localparam int PIN_SI   = 6;
    localparam int PIN_HALT = 7;
    // reset values and masks
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] GCFG_WR_MASK = 8'h3f;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    // timing: one instruction cycle per clock
    localparam int MCLK_NS = 50;
    localparam int TC_NS   = 50;
    localparam int TC_CYC  = TC_NS / MCLK_NS;
    localparam int SK_PER_TC_0 = 2;
    localparam int SK_PER_TC_1 = 4;
    localparam int SK_PER_TC_2 = 8;
    localparam logic [2:0] SK_HALF_0 = 3'(SK_PER_TC_0 * TC_CYC / 2);
    localparam logic [2:0] SK_HALF_1 = 3'(SK_PER_TC_1 * TC_CYC / 2);
    localparam logic [2:0] SK_HALF_2 = 3'(SK_PER_TC_2 * TC_CYC / 2);

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_SLAVE} ssp_st_e;

    // half period of the internal shift clock in mclk cycles
    function automatic logic [2:0] ssp_half_cyc(input logic [1:0] rate);
        if (rate[1]) begin
            return SK_HALF_2;
        end else if (rate[0]) begin
            return SK_HALF_1;
        end
        return SK_HALF_0;
    endfunction
endpackage

// ---- include/ssp_div_if.sv ----
// link between the port logic and the shift clock divider
`timescale 1ns/1ns
interface ssp_div_if;
    logic       run;
    logic       hold;
    logic [1:0] rate;
    logic       rise;
    logic       fall;
    modport div  (input run, hold, rate, output rise, fall);
    modport user (output run, hold, rate, input rise, fall);
endinterface

// ---- verilog/ssp_sk_div.sv ----
// shift clock divider for master mode
`timescale 1ns/1ns
module ssp_sk_div #(
    parameter int CNT_W = 3
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    ssp_div_if.div    dif
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             sk;
    } ssp_div_s;

    ssp_div_s q_reg;
    ssp_div_s q_next;
    logic [CNT_W-1:0] half;
    logic             tick;

    if (CNT_W < 3) begin : g_chk
        $error("ssp_sk_div: CNT_W too small for the slowest rate");
    end

    // edge pulses fire on the edge where the level changes
    assign half      = CNT_W'(ssp_half_cyc(dif.rate));
    assign tick      = (q_reg.cnt == half - 1'b1);
    assign dif.rise  = dif.run & ~dif.hold & tick & ~q_reg.sk;
    assign dif.fall  = dif.run & ~dif.hold & tick & q_reg.sk;

    // counter restarts low whenever run drops, so every burst starts alike
    always_comb begin
        q_next = q_reg;
        if (dif.hold) begin
            q_next = q_reg;
        end else if (!dif.run) begin
            q_next = '0;
        end else if (tick) begin
            q_next.cnt = '0;
            q_next.sk  = ~q_reg.sk;
        end else begin
            q_next.cnt = q_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    property p_fast_half;
        @(posedge mclk) disable iff (!reset_n)
        (dif.rise && dif.rate == 2'b00) |=> (dif.fall || !dif.run || dif.hold);
    endproperty
    a_fast_half: assert property (p_fast_half) else $error("rate 00 high phase not one cycle"); // R4

    property p_slow_half;
        @(posedge mclk) disable iff (!reset_n)
        (dif.rise && dif.rate[1] && dif.run) |=> !dif.fall [*3];
    endproperty
    a_slow_half: assert property (p_slow_half) else $error("rate 1x high phase too short"); // R4
endmodule

// ---- verilog/ssp_top.sv ----
// serial shift port with port pins, halt control and register slave
//
// Behaviour
// R1: eight-bit shift register moves data on clock
// R2: internal clock master, external clock slave
// R3: select bit enables port, routes pins four/five
// R4: rate bits pick 2, 4 or 8 cycles
// R5: writing busy one starts shifting
// R6: busy clears itself after eight bits
// R7: clearing busy early ends the transfer
// R8: pin roles follow configuration bits
// R9: only a master ever starts a transfer
// R10: slave keeps shifting while external clock runs
// R11: busy set with clock high shifts once
// R12: load shift register only while clock low
// R13: slave software sets busy early, clock low
// R14: reset clears status and control registers
// R15: reset clears port registers, pins float
// R16: port seven data one freezes everything
// R17: halt ends on pin seven rise or reset
// R18: software follows halt entry with two no-ops
// R19: control and status registers are memory mapped
// R20: msb first, out on fall, in on rise
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module ssp_top #(
    parameter int PADDR_W = 12
) (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [PADDR_W-1:0]          paddr,
    input  wire logic [ssp_pkg::DATA_W-1:0]  pwdata,
    output logic      [ssp_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [7:0]                  g_in,
    output logic      [5:0]                  g_out,
    output logic      [5:0]                  g_oe_n
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [7:0]        gdata;
        logic [7:0]        gcfg;
        logic [7:0]        ctrl;
        logic [7:0]        processor_status_reg;
        logic [7:0]        sr;
        logic              so;
        logic [3:0]        bitcnt;
        logic [2:0]        mrise_dly;
        ssp_st_e           st;
        logic              halted;
        logic [7:0]        s1;
        logic [7:0]        s2;
        logic              g7_prev;
        logic              ik_prev;
        logic              sk_pin;
        logic [5:0]        g_out;
        logic [5:0]        g_oe_n;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } ssp_state_s;

    ssp_state_s q_reg;
    ssp_state_s q_next;

    logic       hit;
    logic [7:0] idx;
    logic [7:0] rd_byte;
    logic       wr;
    logic       wr_psw;
    logic       master;
    logic       slave;
    logic       busy;
    logic       ik_now;
    logic       s_rise;
    logic       s_fall;
    logic [7:0] shift_in;

    ssp_div_if dif ();

    ssp_sk_div u_div (
        .mclk    (mclk),
        .reset_n (reset_n),
        .dif     (dif)
    );

    if (PADDR_W < IDX_MSB + 2) begin : g_chk
        $error("ssp_top: PADDR_W too narrow for the register map");
    end

    // divider runs only during a master burst and freezes in halt
    assign dif.run  = (q_reg.st == ST_SHIFT);
    assign dif.hold = q_reg.halted;
    assign dif.rate = {q_reg.ctrl[CTRL_SL1], q_reg.ctrl[CTRL_SL0]}; // R4

    // address decode: aligned word, upper bits zero
    assign idx = paddr[IDX_MSB:IDX_LSB];
    always_comb begin
        hit     = (paddr[IDX_LSB-1:0] == '0) && (paddr[PADDR_W-1:IDX_MSB+1] == '0);
        rd_byte = RST_BYTE;
        unique case (idx)
            IDX_GDATA: rd_byte = q_reg.gdata;
            IDX_GCFG:  rd_byte = q_reg.gcfg;
            IDX_GPIN:  rd_byte = q_reg.s2;
            IDX_SIO:   rd_byte = q_reg.sr;
            IDX_CTRL:  rd_byte = q_reg.ctrl; // R19
            IDX_PSW:   rd_byte = q_reg.processor_status_reg;  // R19
            default:   hit = 1'b0;
        endcase
    end

    // a write lands on the access edge; frozen core ignores writes in halt
    assign wr     = psel & penable & q_reg.pready & pwrite & ~q_reg.pslverr & ~q_reg.halted;
    assign wr_psw = wr & (idx == IDX_PSW);

    // mode decode from select bit and clock pin direction
    assign master = q_reg.ctrl[CTRL_SERIAL_PORT_SELECT] & q_reg.gcfg[PIN_SK];  // R2 R3
    assign slave  = q_reg.ctrl[CTRL_SERIAL_PORT_SELECT] & ~q_reg.gcfg[PIN_SK]; // R2 R3
    assign busy   = q_reg.processor_status_reg[PSW_BUSY];

    // slave internal clock is the synced pin gated by the active state
    assign ik_now   = q_reg.s2[PIN_SK] & (q_reg.st == ST_SLAVE); // R10 R11
    assign s_rise   = (q_reg.st == ST_SHIFT) ? dif.rise : (ik_now & ~q_reg.ik_prev);
    assign s_fall   = (q_reg.st == ST_SHIFT) ? dif.fall : (~ik_now & q_reg.ik_prev);
    assign shift_in = {q_reg.sr[6:0], q_reg.s2[PIN_SI]};

    always_comb begin
        q_next = q_reg;
        // two-flop synchronisers on every port pin input
        q_next.s1      = g_in;
        q_next.s2      = q_reg.s1;
        q_next.g7_prev = q_reg.s2[PIN_HALT];
        // bus answer one cycle after setup, so pready comes from a flop
        q_next.pready  = 1'b0;
        q_next.pslverr = 1'b0;
        if (psel && !penable) begin
            q_next.pready  = 1'b1;
            q_next.pslverr = ~hit;
            q_next.prdata  = hit ? {24'h000000, rd_byte} : '0;
        end
        if (q_reg.halted) begin
            // everything else held exactly; only a pin seven rise or a reset wakes us
            if (q_reg.s2[PIN_HALT] && !q_reg.g7_prev) begin
                q_next.halted = 1'b0; // R17
            end
        end else begin
            q_next.ik_prev = ik_now;
            // drop out when the mode no longer matches the state
            unique case (q_reg.st)
                ST_IDLE:  q_next.st = ST_IDLE;
                ST_SHIFT: if (!master || !busy) q_next.st = ST_IDLE;
                ST_SLAVE: if (!slave) q_next.st = ST_IDLE;
            endcase
            // sample on rise, msb first
            if (s_rise) begin
                q_next.sr = shift_in; // R1 R20
                if (busy && q_reg.bitcnt != BITS_PER_XFER) begin
                    q_next.bitcnt = q_reg.bitcnt + 1'b1;
                end
            end
            // drive next bit on fall; the byte ends when the clock is low again
            if (s_fall) begin
                q_next.so = q_reg.sr[7]; // R20
                if (busy && q_reg.bitcnt == BITS_PER_XFER) begin
                    q_next.processor_status_reg[PSW_BUSY] = 1'b0; // R6
                    if (q_reg.st == ST_SHIFT) begin
                        q_next.st = ST_IDLE;
                    end
                end
            end
            // master input lands three cycles late: the pin we raise only then
            // reaches the second sync flop; a rise in between moved the slot up
            q_next.mrise_dly = {q_reg.mrise_dly[1:0], (q_reg.st == ST_SHIFT) & dif.rise};
            if (q_reg.mrise_dly[2]) begin
                q_next.sr[q_reg.mrise_dly[0]] = q_reg.s2[PIN_SI]; // R1 R20
            end
            // software writes come last so a set beats the self-clear
            if (wr) begin
                unique case (idx)
                    IDX_GDATA: begin
                        q_next.gdata = pwdata[7:0];
                        if (pwdata[PIN_HALT]) begin
                            q_next.halted = 1'b1; // R16
                        end
                    end
                    IDX_GCFG: q_next.gcfg = pwdata[7:0] & GCFG_WR_MASK;
                    IDX_SIO:  q_next.sr   = pwdata[7:0]; // R12
                    IDX_CTRL: q_next.ctrl = pwdata[7:0];
                    IDX_PSW: begin
                        q_next.processor_status_reg = pwdata[7:0];
                        if (pwdata[PSW_BUSY] && !busy) begin
                            q_next.bitcnt = '0; // R5
                            q_next.so     = q_reg.sr[7];
                            if (master) begin
                                q_next.st = ST_SHIFT; // R5 R9
                            end else if (slave) begin
                                q_next.st = ST_SLAVE; // R11 R13
                            end
                        end else if (!pwdata[PSW_BUSY] && q_reg.st == ST_SHIFT) begin
                            q_next.st = ST_IDLE; // R7
                        end
                    end
                    default: q_next.gdata = q_reg.gdata;
                endcase
            end
            // master clock pin follows the divider edges and parks low
            if (q_next.st != ST_SHIFT) begin
                q_next.sk_pin = 1'b0; // R9
            end else if (s_rise) begin
                q_next.sk_pin = 1'b1;
            end else if (s_fall) begin
                q_next.sk_pin = 1'b0;
            end
        end
        // pins from next state so outputs stay flop-driven with no lag
        q_next.g_out  = q_next.gdata[5:0];
        q_next.g_oe_n = ~q_next.gcfg[5:0];
        if (q_next.ctrl[CTRL_SERIAL_PORT_SELECT]) begin
            q_next.g_out[PIN_SO] = q_next.so;     // R3 R8
            q_next.g_out[PIN_SK] = q_next.sk_pin; // R8
        end
    end

    // weak pull-up setting is not modelled; such pins simply float
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q_reg        <= '0;  // R14 R15
            q_reg.g_oe_n <= '1;  // R15
        end else begin
            q_reg <= q_next;
        end
    end

    assign prdata  = q_reg.prdata;
    assign pready  = q_reg.pready;
    assign pslverr = q_reg.pslverr;
    assign g_out   = q_reg.g_out;
    assign g_oe_n  = q_reg.g_oe_n;

    property p_start;
        @(posedge mclk) disable iff (!reset_n)
        (wr_psw && pwdata[PSW_BUSY] && !busy && master) |=> (q_reg.st == ST_SHIFT);
    endproperty
    a_start: assert property (p_start) else $error("master burst did not start"); // R5

    property p_self_clear;
        @(posedge mclk) disable iff (!reset_n)
        (s_fall && busy && q_reg.bitcnt == BITS_PER_XFER && !wr && !q_reg.halted)
            |=> !q_reg.processor_status_reg[PSW_BUSY] ##1 !q_reg.processor_status_reg[PSW_BUSY] || q_reg.st != ST_IDLE;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("busy not cleared after 8 bits"); // R6

    property p_early_stop;
        @(posedge mclk) disable iff (!reset_n)
        (wr_psw && !pwdata[PSW_BUSY] && q_reg.st == ST_SHIFT)
            |=> (q_reg.st == ST_IDLE && !q_reg.sk_pin);
    endproperty
    a_early_stop: assert property (p_early_stop) else $error("cleared busy did not stop"); // R7

    property p_slave_no_clock;
        @(posedge mclk) disable iff (!reset_n)
        (q_reg.st == ST_SLAVE) |-> !q_reg.sk_pin;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drove clock"); // R9

    property p_slave_keeps;
        @(posedge mclk) disable iff (!reset_n)
        (q_reg.st == ST_SLAVE && slave && !busy && s_rise && !wr && !q_reg.halted)
            |=> (q_reg.sr == $past(shift_in));
    endproperty
    a_slave_keeps: assert property (p_slave_keeps) else $error("idle slave missed a shift"); // R10

    property p_narrow;
        @(posedge mclk) disable iff (!reset_n)
        ($rose(q_reg.st == ST_SLAVE) && q_reg.s2[PIN_SK] && !q_reg.halted) |-> s_rise;
    endproperty
    a_narrow: assert property (p_narrow) else $error("busy with clock high gave no edge"); // R11

    property p_reset;
        @(posedge mclk) disable iff (1'b0)
        !reset_n |=> (q_reg.ctrl == RST_BYTE && q_reg.processor_status_reg == RST_BYTE && g_oe_n == 6'h3f);
    endproperty
    a_reset: assert property (p_reset) else $error("reset left state behind"); // R14 R15

    property p_freeze;
        @(posedge mclk) disable iff (!reset_n)
        q_reg.halted |=> ($stable(q_reg.sr) && $stable(q_reg.processor_status_reg) && $stable(g_out));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved during halt"); // R16

    property p_wake;
        @(posedge mclk) disable iff (!reset_n)
        (q_reg.halted && q_reg.s2[PIN_HALT] && !q_reg.g7_prev) |=> !q_reg.halted;
    endproperty
    a_wake: assert property (p_wake) else $error("pin seven rise did not wake"); // R17

    property p_pin_route;
        @(posedge mclk) disable iff (!reset_n)
        g_out[PIN_SO] == (q_reg.ctrl[CTRL_SERIAL_PORT_SELECT] ? q_reg.so : q_reg.gdata[PIN_SO]);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("serial out misrouted"); // R3 R8
endmodule

// ---- tb/ssp_peer.sv ----
// behavioural serial peripheral on the far side of the shift port pins
`timescale 1ns/1ns
module ssp_peer (
    input  wire logic sk_pin,
    input  wire logic so_pin,
    output logic      si_out,
    output logic      sk_out,
    output logic      sk_oe
);
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    int         n_rise;

    // idle: clock released, input line low
    initial begin
        si_out = 1'b0;
        sk_out = 1'b0;
        sk_oe = 1'b0;
        tx_reg = 8'h00;
        rx_reg = 8'h00;
        n_rise = 0;
    end

    // capture serial out on the rise, msb first
    always @(posedge sk_pin) begin
        rx_reg <= {rx_reg[6:0], so_pin};
        n_rise <= n_rise + 1;
    end

    // next bit leaves on the fall, so it is settled long before the rise
    always @(negedge sk_pin) begin
        si_out <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
    end

    // first bit is presented at once, the rest follow each fall
    task automatic load(input logic [7:0] b);
        si_out = b[7];
        tx_reg = {b[6:0], 1'b0};
    endtask

    // hold the clock line at a level, or release it
    task automatic drive(input logic oe, input logic lvl);
        sk_oe = oe;
        sk_out = lvl;
    endtask

    // frame of n clocks at 400 ns; the clock stands low outside frames
    task automatic clock_bits(input int n);
        sk_oe = 1'b1;
        #13;
        repeat (n) begin
            #200 sk_out = 1'b1;
            #200 sk_out = 1'b0;
        end
    endtask
endmodule

// ---- tb/tb_top.sv ----
// top testbench for the serial shift port
`timescale 1ns/1ns
module tb_top;
    import ssp_pkg::*;
    localparam logic [7:0] BUSY_B = 8'h01 << PSW_BUSY;
    localparam logic [7:0] SEL_B  = 8'h01 << CTRL_SERIAL_PORT_SELECT;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        wake, si_w, sk_w, sk_oe_w, so_alt, sk_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  g_in;
    logic [5:0]  g_out, g_oe_n;
    logic [3:0]  pin_lo;
    int          miscompares, n_checks, sk_rises, sk_per, cyc, last_rise;

    ssp_top #(.PADDR_W(12)) dut_u (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .g_in(g_in),
        .g_out(g_out), .g_oe_n(g_oe_n));
    ssp_peer peer_u (.sk_pin(g_in[PIN_SK]), .so_pin(g_in[PIN_SO]), .si_out(si_w),
        .sk_out(sk_w), .sk_oe(sk_oe_w));

    // pin levels; a floating serial out toggles so a stale value never passes
    assign g_in[PIN_SO] = g_oe_n[PIN_SO] ? so_alt : g_out[PIN_SO];
    assign g_in[PIN_SK] = !g_oe_n[PIN_SK] ? g_out[PIN_SK] : (sk_oe_w & sk_w);
    assign g_in[PIN_SI] = si_w;
    assign g_in[PIN_HALT] = wake;
    assign g_in[3:0] = pin_lo;

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // counts driven shift clock rises and their spacing in mclk cycles
    always @(posedge mclk) begin
        so_alt <= ~so_alt;
        cyc <= cyc + 1;
        sk_q <= g_out[PIN_SK];
        if (!g_oe_n[PIN_SK] && g_out[PIN_SK] && !sk_q) begin
            sk_rises <= sk_rises + 1;
            sk_per <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 50) miscompares++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        logic       e;
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       e;
        apb(1'b0, idx, 8'h00, d, e);
        chk({24'h0, d}, {24'h0, exp});
    endtask

    task automatic ncyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // poll status until busy drops, bounded
    task automatic wait_idle;
        logic [7:0] d;
        logic       e;
        int         n;
        n = 0;
        d = BUSY_B;
        while ((d & BUSY_B) !== 8'h00 && n < 60) begin
            apb(1'b0, IDX_PSW, 8'h00, d, e);
            n++;
        end
        chk(32'(n < 60), 32'd1);
    endtask

    task automatic t_reset;
        logic [7:0] d;
        logic       e;
        reset_n <= 1'b0;
        ncyc(2);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk(32'(g_oe_n), 32'h3f);
        chk(32'(g_out), 32'h0);
        rd_chk(IDX_CTRL, 8'h00);
        rd_chk(IDX_PSW, 8'h00);
        rd_chk(IDX_GDATA, 8'h00);
        rd_chk(IDX_GCFG, 8'h00);
        wr(IDX_GCFG, 8'hff);
        rd_chk(IDX_GCFG, GCFG_WR_MASK);
        apb(1'b0, IDX_GPIN, 8'h00, d, e);
        chk(32'(d[3:0]), 32'ha);
        apb(1'b0, 8'h10, 8'h00, d, e);
        chk({31'h0, e}, 32'h1);
        wr(IDX_GCFG, 8'h00);
    endtask

    task automatic t_master(input logic [1:0] rate, input logic [7:0] tx, input logic [7:0] rxb);
        int base, per;
        per = rate[1] ? SK_PER_TC_2 : (rate[0] ? SK_PER_TC_1 : SK_PER_TC_0);
        wr(IDX_GCFG, 8'h30);
        wr(IDX_CTRL, SEL_B | {6'h0, rate});
        wr(IDX_SIO, tx);
        peer_u.load(rxb);
        base = sk_rises;
        wr(IDX_PSW, BUSY_B);
        wait_idle();
        chk(32'(sk_rises - base), 32'd8);
        chk(32'(sk_per), 32'(per * TC_CYC));
        chk({24'h0, peer_u.rx_reg}, {24'h0, tx});
        rd_chk(IDX_SIO, rxb);
    endtask

    // software clears busy after three bits
    task automatic t_early(input logic [7:0] tx, input logic [7:0] rxb);
        int          base, n;
        logic [15:0] both;
        wr(IDX_CTRL, SEL_B | 8'h02);
        wr(IDX_SIO, tx);
        peer_u.load(rxb);
        base = sk_rises;
        wr(IDX_PSW, BUSY_B);
        n = 0;
        while (sk_rises - base < 3 && n < 100) begin
            n++;
            @(posedge mclk);
        end
        wr(IDX_PSW, 8'h00);
        ncyc(40);
        n = sk_rises - base;
        both = {tx, rxb} << n;
        chk(32'(n), 32'd3);
        rd_chk(IDX_SIO, both[15:8]);
    endtask

    task automatic t_nosel;
        int base;
        wr(IDX_CTRL, 8'h00);
        base = sk_rises;
        wr(IDX_PSW, BUSY_B);
        ncyc(40);
        chk(32'(sk_rises - base), 32'd0);
        wr(IDX_PSW, 8'h00);
    endtask

    task automatic t_slave(input logic [7:0] tx, input logic [7:0] rxb);
        int n0;
        wr(IDX_GCFG, 8'h10);
        wr(IDX_CTRL, SEL_B);
        wr(IDX_SIO, tx);
        peer_u.load(rxb);
        peer_u.drive(1'b1, 1'b0);
        wr(IDX_PSW, BUSY_B);
        n0 = peer_u.n_rise;
        ncyc(20);
        chk(32'(peer_u.n_rise - n0), 32'd0);
        chk({31'h0, g_oe_n[PIN_SK]}, 32'h1);
        chk({31'h0, g_oe_n[PIN_SO]}, 32'h0);
        peer_u.clock_bits(8);
        ncyc(6);
        rd_chk(IDX_PSW, 8'h00);
        rd_chk(IDX_SIO, rxb);
        chk({24'h0, peer_u.rx_reg}, {24'h0, tx});
        peer_u.load(8'hf0);
        peer_u.clock_bits(4);
        ncyc(6);
        rd_chk(IDX_SIO, {rxb[3:0], 4'hf});
    endtask

    // busy set while the far clock is already high
    task automatic t_hi_start;
        wr(IDX_CTRL, 8'h00);
        wr(IDX_SIO, 8'h00);
        peer_u.load(8'h80);
        peer_u.drive(1'b1, 1'b1);
        wr(IDX_CTRL, SEL_B);
        wr(IDX_PSW, BUSY_B);
        ncyc(6);
        rd_chk(IDX_SIO, 8'h01);
        wr(IDX_PSW, 8'h00);
        peer_u.drive(1'b1, 1'b0);
        ncyc(4);
        peer_u.drive(1'b0, 1'b0);
    endtask

    // halt mid-transfer, then wake by a pin rise
    task automatic t_halt(input logic [7:0] tx, input logic [7:0] rxb);
        int         base, k;
        logic [5:0] snap;
        wr(IDX_GCFG, 8'h30);
        wr(IDX_CTRL, SEL_B | 8'h02);
        wr(IDX_SIO, tx);
        peer_u.load(rxb);
        base = sk_rises;
        wr(IDX_PSW, BUSY_B);
        k = 0;
        while (sk_rises - base < 2 && k < 100) begin
            k++;
            @(posedge mclk);
        end
        wr(IDX_GDATA, 8'h80);
        snap = g_out;
        k = sk_rises;
        ncyc(40);
        chk(32'(g_out), 32'(snap));
        chk(32'(sk_rises - k), 32'd0);
        wr(IDX_CTRL, 8'h00);
        rd_chk(IDX_CTRL, SEL_B | 8'h02);
        wake <= 1'b1;
        ncyc(2);
        wait_idle();
        wake <= 1'b0;
        chk(32'(sk_rises - base), 32'd8);
        rd_chk(IDX_SIO, rxb);
    endtask

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wake = 1'b0;
        pin_lo = 4'ha;
        so_alt = 1'b0;
        sk_q = 1'b0;
        miscompares = 0;
        n_checks = 0;
        sk_rises = 0;
        sk_per = 0;
        cyc = 0;
        last_rise = 0;
        t_reset();
        t_master(2'b00, 8'ha5, 8'h3c);
        t_master(2'b01, 8'h5a, 8'hc3);
        t_master(2'b10, 8'h81, 8'h7e);
        t_master(2'b11, 8'h18, 8'he7);
        t_early(8'hb4, 8'h6d);
        t_nosel();
        t_slave(8'h96, 8'h2b);
        t_hi_start();
        t_halt(8'hc6, 8'h39);
        // halt again so the closing reset must also end halt for its writes to land
        wr(IDX_GDATA, 8'h80);
        t_reset();
        final_report();
    end

    // cuts a hang short well past the expected run length
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
endmodule
